// File: rtl/mdscc_top.sv
// Configuration loader for one device of a cascaded serial configuration
// chain. Works as master (drives the serial clock and reads the memory) or
// as slave (samples the shared clock and data), chosen by a strap pin.
// Assumes every input pin is asynchronous; open-drain pins are split into
// level in, constant-low out and an enable that is high while pulling low.
//
// Functional notes
// - After capturing its own share, the device drives chain enable output low.
// - Last device's chain enable output may float or become user I/O.
// - A device strapped active serial is master and generates the serial clock.
// - Chain enable output goes low together with release of the complete line.
// - Complete line is held low until this device has its whole bitstream.
// - Initialization starts only when the shared complete line reads high.
// - Status and complete pins are open-drain: pull low or release, sense level.
// - A detected configuration error pulls the shared status line low.
// - Auto restart reconfigures after an error timeout of at most 80 us.
// - Master holds chain enable output high while reading its own image.
// - Then master drives it low and keeps clocking the next image out.
// - Single-image method loads master, then each slave in turn, in one cycle.
// - Compressed or plain images accepted; compressed ones expand on receipt.
// - Master changes outputs and samples data on the falling serial clock.
// - After the complete line rises, count 3,180 cycles before user mode.
`timescale 1ns/1ps
module mdscc_top
   import mdscc_pkg::*;
#(
   parameter int IMAGE_BITS     = 4096,
   parameter int RESTART_CYCLES = RESTART_CYC,
   parameter bit CEO_USER_IO    = 1'b1
)
(
   input  wire logic CLK_IN,
   input  wire logic RST_N_IN,
   input  wire logic CONFIG_REQUEST_N_IN,
   input  wire logic CONFIG_STATUS_N_IN,
   input  wire logic CONFIG_COMPLETE_IN,
   input  wire logic CHAIN_ENABLE_IN_N_IN,
   input  wire logic SERIAL_CONFIG_CLOCK_IN,
   input  wire logic CONFIG_DATA_IN,
   input  wire logic ACTIVE_SERIAL_SCHEME_IN,
   input  wire logic COMPRESSED_IMAGE_IN,
   input  wire logic AUTO_RESTART_IN,
   output logic      CONFIG_STATUS_N_OUT,
   output logic      CONFIG_STATUS_N_OE_OUT,
   output logic      CONFIG_COMPLETE_OUT,
   output logic      CONFIG_COMPLETE_OE_OUT,
   output logic      SERIAL_CONFIG_CLOCK_OUT,
   output logic      SERIAL_CONFIG_CLOCK_OE_OUT,
   output logic      MEMORY_SELECT_N_OUT,
   output logic      MEMORY_CMD_DATA_OUT,
   output logic      CHAIN_ENABLE_OUT_N_OUT,
   output logic      CHAIN_ENABLE_OUT_N_OE_OUT,
   output logic      USER_MODE_OUT
);

   logic [1:0]        rst_pipe_reg;
   logic              rst_n;
   mdscc_pins_t       pins_raw;
   mdscc_pins_t       sync1_reg;
   mdscc_pins_t       sync2_reg;
   logic              sclk_prev_reg;
   mdscc_state_t      state_reg;
   logic              master_reg;
   logic [DIV_W-1:0]  div_reg;
   logic              sclk_run;
   logic              fall_evt;
   logic              rise_evt;
   logic [CMD_BITS-1:0] cmd_shift_reg;
   logic [5:0]        cmd_cnt_reg;
   logic [CNT_W-1:0]  timer_reg;
   logic              bit_valid;
   logic              sink_clear;
   logic              sink_done;
   logic              sink_error;
   logic              fault;
   logic              primed_reg;

   // -----------------------------------------------------------------
   // Reset release and pin synchronisers
   // -----------------------------------------------------------------
   // Assertion is immediate; release passes two flops to avoid a runt edge.
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         rst_pipe_reg <= 2'h0;
      else
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
   end

   assign rst_n = rst_pipe_reg[1];

   assign pins_raw = '{CONFIG_REQUEST_N_IN, CONFIG_STATUS_N_IN, CONFIG_COMPLETE_IN,
                       CHAIN_ENABLE_IN_N_IN, SERIAL_CONFIG_CLOCK_IN, CONFIG_DATA_IN,
                       ACTIVE_SERIAL_SCHEME_IN, COMPRESSED_IMAGE_IN, AUTO_RESTART_IN};

   // The first stage feeds only the second; all logic reads the second.
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_reg     <= PINS_RESET;
         sync2_reg     <= PINS_RESET;
         sclk_prev_reg <= 1'b1;
      end
      else
      begin
         sync1_reg     <= pins_raw;
         sync2_reg     <= sync1_reg;
         sclk_prev_reg <= sync2_reg.sclk;
      end
   end

   // -----------------------------------------------------------------
   // Serial clock generation and edge events
   // -----------------------------------------------------------------
   // master drives serial clock
   assign sclk_run = master_reg &&
                     (state_reg == MDSCC_CMD || state_reg == MDSCC_LOAD || state_reg == MDSCC_WAIT);
   assign fall_evt = sclk_run && (div_reg == DIV_W'(SCLK_HIGH_CYC - 1));
   // A slave sees the master's clock only through the synchroniser, so its
   // rising edge arrives two system cycles late; data is delayed equally.
   assign rise_evt = sync2_reg.sclk && !sclk_prev_reg;

   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_reg                    <= 4'h0;
         SERIAL_CONFIG_CLOCK_OUT    <= 1'b1;
         SERIAL_CONFIG_CLOCK_OE_OUT <= 1'b0;
      end
      else if (sclk_run)
      begin
         if (div_reg == DIV_W'(SCLK_PERIOD_CYC - 1))
            div_reg <= 4'h0;
         else
            div_reg <= div_reg + 4'h1;
         SERIAL_CONFIG_CLOCK_OUT    <= (div_reg == DIV_W'(SCLK_PERIOD_CYC - 1)) ||
                                       (div_reg < DIV_W'(SCLK_HIGH_CYC - 1));
         SERIAL_CONFIG_CLOCK_OE_OUT <= 1'b1;
      end
      else
      begin
         div_reg                    <= 4'h0;
         SERIAL_CONFIG_CLOCK_OUT    <= 1'b1;
         SERIAL_CONFIG_CLOCK_OE_OUT <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Bit capture into the sink
   // -----------------------------------------------------------------
   // load only while enabled
   assign bit_valid  = (state_reg == MDSCC_LOAD) && !sync2_reg.chain_en_n &&
                       (master_reg ? fall_evt && primed_reg : rise_evt);
   assign sink_clear = (state_reg == MDSCC_RESET);
   // own error or a low status line
   assign fault      = sink_error || (!sync2_reg.status_n &&
                       (state_reg == MDSCC_CMD || state_reg == MDSCC_LOAD || state_reg == MDSCC_WAIT));

   // The first load fall carries no memory data yet.
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
         primed_reg <= 1'b0;
      else
         primed_reg <= (state_reg == MDSCC_LOAD) && (primed_reg || fall_evt);
   end

   mdscc_sink #(
      .IMAGE_BITS (IMAGE_BITS)
   ) u_sink (
      .clk_in        (CLK_IN),
      .rst_n_in      (rst_n),
      .clear_in      (sink_clear),
      .bit_valid_in  (bit_valid),
      .bit_in        (sync2_reg.data),
      .compressed_in (sync2_reg.compressed),
      .done_out      (sink_done),
      .error_out     (sink_error)
   );

   // -----------------------------------------------------------------
   // Configuration sequence
   // -----------------------------------------------------------------
   // A low request forces reset from any state; the pulse width is the
   // controller's concern, any low seen after synchronisation counts.
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg  <= MDSCC_RESET;
         master_reg <= 1'b0;
         timer_reg  <= 16'h0000;
      end
      else if (!sync2_reg.request_n)
      begin
         state_reg <= MDSCC_RESET;
         timer_reg <= 16'h0000;
      end
      else
      begin
         case (state_reg)
            MDSCC_RESET:
            begin
               // Strap is caught as the status line releases.
               master_reg <= sync2_reg.master;
               if (sync2_reg.status_n)
                  state_reg <= sync2_reg.master ? MDSCC_CMD : MDSCC_LOAD;
            end
            MDSCC_CMD:
            begin
               if (fault)
                  state_reg <= MDSCC_ERROR;
               else if (fall_evt && cmd_cnt_reg == 6'(CMD_BITS - 1))
                  state_reg <= MDSCC_LOAD;
            end
            MDSCC_LOAD:
            begin
               if (fault)
                  state_reg <= MDSCC_ERROR;
               else if (sink_done)
                  state_reg <= MDSCC_WAIT;
            end
            MDSCC_WAIT:
            begin
               timer_reg <= 16'h0000;
               if (fault)
                  state_reg <= MDSCC_ERROR;
               else if (sync2_reg.complete)
                  state_reg <= MDSCC_INIT;
            end
            MDSCC_INIT:
            begin
               if (timer_reg == CNT_W'(INIT_CYCLES - 1))
                  state_reg <= MDSCC_USER;
               else
                  timer_reg <= timer_reg + 16'h0001;
            end
            MDSCC_USER:
               state_reg <= MDSCC_USER;
            MDSCC_ERROR:
            begin
               if (timer_reg == CNT_W'(RESTART_CYCLES - 1))
               begin
                  timer_reg <= 16'h0000;
                  state_reg <= sync2_reg.auto_restart ? MDSCC_RESET : MDSCC_HALT;
               end
               else
                  timer_reg <= timer_reg + 16'h0001;
            end
            MDSCC_HALT:
               state_reg <= MDSCC_HALT;
            default:
               state_reg <= MDSCC_RESET;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Memory command shifter
   // -----------------------------------------------------------------
   // Opcode and start address go out MSB first, one bit per falling edge,
   // so the memory latches each on the following rising edge.
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_shift_reg       <= {READ_OPCODE, START_ADDR};
         cmd_cnt_reg         <= 6'h00;
         MEMORY_CMD_DATA_OUT <= 1'b0;
         MEMORY_SELECT_N_OUT <= 1'b1;
      end
      else if (state_reg == MDSCC_CMD)
      begin
         MEMORY_SELECT_N_OUT <= 1'b0;
         if (fall_evt)
         begin
            MEMORY_CMD_DATA_OUT <= cmd_shift_reg[CMD_BITS-1];
            cmd_shift_reg       <= {cmd_shift_reg[CMD_BITS-2:0], 1'b0};
            cmd_cnt_reg         <= cmd_cnt_reg + 6'h01;
         end
      end
      else
      begin
         cmd_shift_reg       <= {READ_OPCODE, START_ADDR};
         cmd_cnt_reg         <= 6'h00;
         MEMORY_CMD_DATA_OUT <= 1'b0;
         // Select stays low through the slave pass; error and reset pulse it high.
         MEMORY_SELECT_N_OUT <= !(master_reg && (state_reg == MDSCC_LOAD || state_reg == MDSCC_WAIT));
      end
   end

   // -----------------------------------------------------------------
   // Open-drain status and complete lines
   // -----------------------------------------------------------------
   // pull low or release only
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         CONFIG_STATUS_N_OUT    <= 1'b0;
         CONFIG_STATUS_N_OE_OUT <= 1'b1;
         CONFIG_COMPLETE_OUT    <= 1'b0;
         CONFIG_COMPLETE_OE_OUT <= 1'b1;
      end
      else
      begin
         CONFIG_STATUS_N_OUT    <= 1'b0;
         CONFIG_COMPLETE_OUT    <= 1'b0;
         CONFIG_STATUS_N_OE_OUT <= !sync2_reg.request_n || state_reg == MDSCC_HALT ||
                                   (state_reg == MDSCC_ERROR && !(fault_timer_done() && sync2_reg.auto_restart));
         CONFIG_COMPLETE_OE_OUT <= !(state_reg == MDSCC_WAIT || state_reg == MDSCC_INIT ||
                                     state_reg == MDSCC_USER || (state_reg == MDSCC_LOAD && sink_done));
      end
   end

   // Status is held low for the whole timeout, then released before restart.
   function automatic logic fault_timer_done();
      fault_timer_done = (timer_reg == CNT_W'(RESTART_CYCLES - 1));
   endfunction

   // -----------------------------------------------------------------
   // Chain enable output and user mode flag
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge rst_n)
   begin
      if (!rst_n)
      begin
         CHAIN_ENABLE_OUT_N_OUT    <= 1'b1;
         CHAIN_ENABLE_OUT_N_OE_OUT <= 1'b1;
         USER_MODE_OUT             <= 1'b0;
      end
      else
      begin
         USER_MODE_OUT <= (state_reg == MDSCC_USER);
         // hand pin over in user mode
         CHAIN_ENABLE_OUT_N_OE_OUT <= !(CEO_USER_IO && state_reg == MDSCC_USER);
         if (state_reg == MDSCC_RESET || state_reg == MDSCC_CMD)
            CHAIN_ENABLE_OUT_N_OUT <= 1'b1;
         else if (state_reg == MDSCC_LOAD && sink_done)
            CHAIN_ENABLE_OUT_N_OUT <= 1'b0;
      end
   end

endmodule

// File: inc/mdscc_pkg.sv
// Shared constants and types for the chained serial configuration loader.
// Assumes a 200 MHz system clock; every pin level arrives unsynchronised.
package mdscc_pkg;

   // -----------------------------------------------------------------
   // Clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ            = 200;
   localparam int SCLK_MAX_MHZ       = 40;
   // Shortest serial clock period, rounded up so the clock never runs too fast.
   localparam int SCLK_PERIOD_CYC    = (CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
   localparam int SCLK_HIGH_CYC      = SCLK_PERIOD_CYC / 2;
   localparam int RESTART_TIMEOUT_NS = 80000;
   // Longest time, so rounded down.
   localparam int RESTART_CYC        = (RESTART_TIMEOUT_NS * CLK_MHZ) / 1000;
   localparam int INIT_CYCLES        = 3180;
   localparam int CNT_W              = 16;
   localparam int DIV_W              = 4;

   // -----------------------------------------------------------------
   // Memory read command and image format
   // -----------------------------------------------------------------
   localparam int          CMD_BITS    = 32;
   localparam logic [7:0]  READ_OPCODE = 8'h03;
   localparam logic [23:0] START_ADDR  = 24'h000000;
   localparam int          BYTE_BITS   = 8;
   localparam int          RUN_MSB     = 6;
   localparam int          VALUE_BIT   = 7;
   localparam int          BITS_W      = 32;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [7:0] {
      MDSCC_RESET = 8'h01,
      MDSCC_CMD   = 8'h02,
      MDSCC_LOAD  = 8'h04,
      MDSCC_WAIT  = 8'h08,
      MDSCC_INIT  = 8'h10,
      MDSCC_USER  = 8'h20,
      MDSCC_ERROR = 8'h40,
      MDSCC_HALT  = 8'h80
   } mdscc_state_t;

   typedef struct packed {
      logic request_n;
      logic status_n;
      logic complete;
      logic chain_en_n;
      logic sclk;
      logic data;
      logic master;
      logic compressed;
      logic auto_restart;
   } mdscc_pins_t;

   localparam mdscc_pins_t PINS_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// File: rtl/mdscc_sink.sv
// Bitstream sink: packs serial bits into bytes, expands compressed runs
// and checks the trailing sum byte. Same clock and reset as the top.
`timescale 1ns/1ps
module mdscc_sink
   import mdscc_pkg::*;
#(
   parameter int IMAGE_BITS = 4096
)
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic clear_in,
   input  wire logic bit_valid_in,
   input  wire logic bit_in,
   input  wire logic compressed_in,
   output logic      done_out,
   output logic      error_out
);

   logic [BYTE_BITS-1:0] shift_reg;
   logic [2:0]           bit_cnt_reg;
   logic [BITS_W-1:0]    expanded_reg;
   logic [BITS_W-1:0]    expanded_next;
   logic [BYTE_BITS-1:0] sum_reg;
   logic                 have_all_reg;
   logic [BYTE_BITS-1:0] byte_now;
   logic                 byte_evt;

   // -----------------------------------------------------------------
   // Byte assembly, MSB first
   // -----------------------------------------------------------------
   assign byte_now = {shift_reg[BYTE_BITS-2:0], bit_in};
   assign byte_evt = bit_valid_in && (bit_cnt_reg == 3'h7) && !done_out && !error_out;

   // A compressed byte holds one bit value and a run length minus one.
   always_comb
   begin
      if (compressed_in)
         expanded_next = expanded_reg + BITS_W'(byte_now[RUN_MSB:0]) + BITS_W'(1);
      else
         expanded_next = expanded_reg + BITS_W'(BYTE_BITS);
   end

   // Shift register runs only while the image is still open.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         shift_reg   <= 8'h00;
         bit_cnt_reg <= 3'h0;
      end
      else if (clear_in)
      begin
         shift_reg   <= 8'h00;
         bit_cnt_reg <= 3'h0;
      end
      else if (bit_valid_in && !done_out && !error_out)
      begin
         shift_reg   <= byte_now;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // -----------------------------------------------------------------
   // Expansion count, sum check and verdict
   // -----------------------------------------------------------------
   // decompress on receipt
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         expanded_reg <= 32'h00000000;
         sum_reg      <= 8'h00;
         have_all_reg <= 1'b0;
         done_out     <= 1'b0;
         error_out    <= 1'b0;
      end
      else if (clear_in)
      begin
         expanded_reg <= 32'h00000000;
         sum_reg      <= 8'h00;
         have_all_reg <= 1'b0;
         done_out     <= 1'b0;
         error_out    <= 1'b0;
      end
      else if (byte_evt)
      begin
         if (have_all_reg)
         begin
            // The byte after the payload is the sum; a mismatch is a frame error.
            done_out  <= (byte_now == sum_reg);
            error_out <= (byte_now != sum_reg);
         end
         else
         begin
            expanded_reg <= expanded_next;
            sum_reg      <= sum_reg + byte_now;
            // A run that overshoots the image size cannot be trimmed safely.
            have_all_reg <= (expanded_next == BITS_W'(IMAGE_BITS));
            error_out    <= (expanded_next > BITS_W'(IMAGE_BITS));
         end
      end
   end

endmodule

// File: verif/mdscc_flash_model.sv
// Behavioural serial configuration memory holding one chain image.
// Assumes the master's clock, select and command pins; data pulls up when idle.
`timescale 1ns/1ps
module mdscc_flash_model
   import mdscc_pkg::*;
(
   input  wire logic        sel_n_in,
   input  wire logic        sclk_in,
   input  wire logic        cmd_in,
   input  wire logic [23:0] image_in,
   output logic             data_out
);
   logic [31:0] cmd_reg = '0;
   int          cnt_reg = 0;
   // Command bits are taken on rising edges; a deselect restarts the count.
   always @(posedge sclk_in or posedge sel_n_in)
      cnt_reg <= sel_n_in ? 0 : cnt_reg + 1;
   always @(posedge sclk_in)
      if (!sel_n_in && cnt_reg < CMD_BITS) cmd_reg <= {cmd_reg[30:0], cmd_in};
   // one concatenated image
   // Data leaves on falling edges after a valid read, else only the pull-up shows.
   always @(negedge sclk_in or posedge sel_n_in)
      if (sel_n_in || cnt_reg < CMD_BITS || cmd_reg != {READ_OPCODE, START_ADDR}) data_out <= 1'b1;
      else data_out <= image_in[23 - (cnt_reg - CMD_BITS) % 24];
endmodule

// File: verif/mdscc_monitor.sv
// Pin checker for the configuration loader, bound to its top module.
// Assumes the complete input is the wired-AND board level.
`timescale 1ns/1ps
module mdscc_monitor
   import mdscc_pkg::*;
#(
   parameter int RESTART_CYCLES = RESTART_CYC
)
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CONFIG_REQUEST_N_IN,
   input wire logic CONFIG_COMPLETE_IN,
   input wire logic CHAIN_ENABLE_IN_N_IN,
   input wire logic ACTIVE_SERIAL_SCHEME_IN,
   input wire logic AUTO_RESTART_IN,
   input wire logic CONFIG_STATUS_N_OUT,
   input wire logic CONFIG_STATUS_N_OE_OUT,
   input wire logic CONFIG_COMPLETE_OUT,
   input wire logic CONFIG_COMPLETE_OE_OUT,
   input wire logic SERIAL_CONFIG_CLOCK_OUT,
   input wire logic MEMORY_SELECT_N_OUT,
   input wire logic MEMORY_CMD_DATA_OUT,
   input wire logic CHAIN_ENABLE_OUT_N_OUT,
   input wire logic USER_MODE_OUT
);
   int init_cnt_reg = 0;
   int err_cnt_reg  = 0;
   // Counts time since the complete line rose, and the length of a status pull.
   always_ff @(posedge CLK_IN)
   begin
      init_cnt_reg <= (CONFIG_COMPLETE_IN && RST_N_IN) ? init_cnt_reg + 1 : 0;
      err_cnt_reg  <= (CONFIG_STATUS_N_OE_OUT && CONFIG_REQUEST_N_IN && RST_N_IN) ? err_cnt_reg + 1 : 0;
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   a_drain_only_low: assert property (!CONFIG_STATUS_N_OUT && !CONFIG_COMPLETE_OUT)
      else $error("open-drain data not low");
   a_ceo_with_done: assert property ($fell(CHAIN_ENABLE_OUT_N_OUT) |-> $fell(CONFIG_COMPLETE_OE_OUT))
      else $error("chain enable fell apart from complete release");
   a_ceo_high_loading: assert property (!MEMORY_SELECT_N_OUT && CONFIG_COMPLETE_OE_OUT |-> CHAIN_ENABLE_OUT_N_OUT)
      else $error("chain enable low during own load");
   a_clock_after_ceo: assert property ($fell(CHAIN_ENABLE_OUT_N_OUT) && ACTIVE_SERIAL_SCHEME_IN
      |-> ##[1:6] $fell(SERIAL_CONFIG_CLOCK_OUT))
      else $error("clock stopped after own load");
   a_cmd_on_fall: assert property (!MEMORY_SELECT_N_OUT && $changed(MEMORY_CMD_DATA_OUT)
      |-> $fell(SERIAL_CONFIG_CLOCK_OUT))
      else $error("command bit changed off the falling clock");
   a_init_after_done: assert property ($rose(USER_MODE_OUT) |-> CONFIG_COMPLETE_IN
      && init_cnt_reg >= INIT_CYCLES && init_cnt_reg <= INIT_CYCLES + 8)
      else $error("user mode at wrong time");
   a_restart_bound: assert property (AUTO_RESTART_IN |-> err_cnt_reg <= RESTART_CYCLES + 6)
      else $error("error pull too long");
   a_slave_ignores: assert property (!ACTIVE_SERIAL_SCHEME_IN && CHAIN_ENABLE_IN_N_IN && $past(CHAIN_ENABLE_IN_N_IN, 4)
      && $past(CONFIG_REQUEST_N_IN, 4) |=> $stable(CHAIN_ENABLE_OUT_N_OUT))
      else $error("disabled slave changed state");
   c_user: cover property ($rose(USER_MODE_OUT));
   c_error: cover property ($rose(CONFIG_STATUS_N_OE_OUT) && CONFIG_REQUEST_N_IN);
   c_slave: cover property ($fell(CHAIN_ENABLE_OUT_N_OUT) && !ACTIVE_SERIAL_SCHEME_IN);
endmodule
bind mdscc_top mdscc_monitor #(.RESTART_CYCLES(RESTART_CYCLES)) u_mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
   .CONFIG_REQUEST_N_IN(CONFIG_REQUEST_N_IN), .CONFIG_COMPLETE_IN(CONFIG_COMPLETE_IN),
   .CHAIN_ENABLE_IN_N_IN(CHAIN_ENABLE_IN_N_IN), .ACTIVE_SERIAL_SCHEME_IN(ACTIVE_SERIAL_SCHEME_IN),
   .AUTO_RESTART_IN(AUTO_RESTART_IN), .CONFIG_STATUS_N_OUT(CONFIG_STATUS_N_OUT),
   .CONFIG_STATUS_N_OE_OUT(CONFIG_STATUS_N_OE_OUT), .CONFIG_COMPLETE_OUT(CONFIG_COMPLETE_OUT),
   .CONFIG_COMPLETE_OE_OUT(CONFIG_COMPLETE_OE_OUT), .SERIAL_CONFIG_CLOCK_OUT(SERIAL_CONFIG_CLOCK_OUT),
   .MEMORY_SELECT_N_OUT(MEMORY_SELECT_N_OUT), .MEMORY_CMD_DATA_OUT(MEMORY_CMD_DATA_OUT),
   .CHAIN_ENABLE_OUT_N_OUT(CHAIN_ENABLE_OUT_N_OUT), .USER_MODE_OUT(USER_MODE_OUT));

// File: verif/test_multi_device_serial_config_chain.sv
// Self-checking bench: one loader as master on a memory model, then as slave.
// Status and complete lines are modelled as wired-AND of this device and the bench's others.
`timescale 1ns/1ps
module test_multi_device_serial_config_chain;
   import mdscc_pkg::*;
   localparam int RST_CYC = 20;
   logic        clk = 0, rst_n = 0, req_n = 1, ext_stat = 1, ext_done = 0, ce_n = 0;
   logic        lclk = 1, ldat = 1, as = 1, comp = 0, ar = 1;
   logic [23:0] img = {8'h5A, 8'hC3, 8'h00};
   logic        st_oe, cp_oe, sc_out, sc_oe, sel_n, cmd, ceo_n, ceo_oe, user, mem_dat;
   int          errors = 0, check_count = 0, n;
   wire         sclk_line = sc_oe ? sc_out : lclk;
   mdscc_flash_model u_mem (.sel_n_in(sel_n), .sclk_in(sclk_line), .cmd_in(cmd), .image_in(img), .data_out(mem_dat));
   mdscc_top #(.IMAGE_BITS(16), .RESTART_CYCLES(RST_CYC), .CEO_USER_IO(1'b1)) u_dut (.CLK_IN(clk), .RST_N_IN(rst_n),
      .CONFIG_REQUEST_N_IN(req_n), .CONFIG_STATUS_N_IN(!st_oe && ext_stat), .CONFIG_COMPLETE_IN(!cp_oe && ext_done),
      .CHAIN_ENABLE_IN_N_IN(ce_n), .SERIAL_CONFIG_CLOCK_IN(sclk_line), .CONFIG_DATA_IN(as ? mem_dat : ldat),
      .ACTIVE_SERIAL_SCHEME_IN(as), .COMPRESSED_IMAGE_IN(comp), .AUTO_RESTART_IN(ar), .CONFIG_STATUS_N_OUT(),
      .CONFIG_STATUS_N_OE_OUT(st_oe), .CONFIG_COMPLETE_OUT(), .CONFIG_COMPLETE_OE_OUT(cp_oe),
      .SERIAL_CONFIG_CLOCK_OUT(sc_out), .SERIAL_CONFIG_CLOCK_OE_OUT(sc_oe), .MEMORY_SELECT_N_OUT(sel_n),
      .MEMORY_CMD_DATA_OUT(cmd), .CHAIN_ENABLE_OUT_N_OUT(ceo_n), .CHAIN_ENABLE_OUT_N_OE_OUT(ceo_oe),
      .USER_MODE_OUT(user));
   // Payload bytes followed by their 8-bit sum, optionally spoiled.
   function automatic logic [23:0] mk_img(logic [7:0] a, logic [7:0] b, logic bad);
      return {a, b, 8'(a + b + {7'h00, bad})};
   endfunction
   task automatic chk_pin(string what, logic exp, logic got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_cnt(string what, int lo, int hi, int got);
      check_count++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   // Bounded wait, sampled away from the launching edge.
   task automatic wait_pin(ref logic s, input logic v, input int lim, output int k);
      for (k = 0; k < lim && s !== v; k++) @(negedge clk);
   endtask
   // request pulse of 110 cycles, longer than the 500 ns minimum.
   task automatic restart();
      @(posedge clk) req_n <= 1'b0;
      repeat (110) @(posedge clk);
      req_n <= 1'b1;
   endtask
   // The link clock runs only inside a frame, out of phase with the system clock.
   task automatic send(logic [23:0] v);
      @(posedge clk) #2.5;
      for (int i = 23; i >= 0; i--)
      begin
         lclk = 1'b0;
         ldat = v[i];
         #32 lclk = 1'b1;
         #32;
      end
      ldat = 1'b1;
   endtask
   task automatic wrap_up();
      if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial forever #2.5 clk = ~clk;
   initial
   begin
      #300000 errors++;
      wrap_up();
   end
   initial
   begin
      n = $urandom(32'h930c331f);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      img <= mk_img(8'h5A, 8'hC3, 1'b1);
      wait_pin(sel_n, 1'b0, 500, n);
      wait_pin(st_oe, 1'b1, 2000, n);
      chk_pin("error pull", 1'b1, st_oe);
      chk_pin("chain enable on error", 1'b1, ceo_n);
      wait_pin(st_oe, 1'b0, 200, n);
      chk_cnt("restart wait", RST_CYC - 2, RST_CYC + 4, n);
      wait_pin(sel_n, 1'b0, 200, n);
      chk_pin("retry select", 1'b0, sel_n);
      @(posedge clk) ar <= 1'b0;
      restart();
      repeat (600) @(negedge clk);
      chk_pin("halt pull", 1'b1, st_oe);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk) img <= mk_img(8'($urandom), 8'($urandom), 1'b0);
         ext_done <= 1'b0;
         restart();
         wait_pin(ceo_n, 1'b0, 3000, n);
         chk_pin("chain enable out", 1'b0, ceo_n);
         chk_pin("complete pull", 1'b0, cp_oe);
         repeat (40) @(negedge clk);
         chk_pin("early user mode", 1'b0, user);
         @(posedge clk) ext_done <= 1'b1;
         wait_pin(user, 1'b1, 4000, n);
         chk_cnt("init cycles", INIT_CYCLES, INIT_CYCLES + 8, n);
         chk_pin("chain enable drive", 1'b0, ceo_oe);
      end
      @(posedge clk) rst_n <= 1'b0;
      as <= 1'b0;
      ce_n <= 1'b1;
      comp <= 1'b1;
      ext_done <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      send({8'h8F, 8'h8F, 8'($urandom)});
      chk_pin("disabled slave", 1'b1, ceo_n);
      @(posedge clk) ce_n <= 1'b0;
      send({8'h8F, 8'h8F, 8'($urandom)});
      wait_pin(ceo_n, 1'b0, 100, n);
      chk_pin("slave chain enable", 1'b0, ceo_n);
      chk_pin("slave complete pull", 1'b0, cp_oe);
      chk_pin("slave clock drive", 1'b0, sc_oe);
      wrap_up();
   end
endmodule
